// ==== common/ddl_consts.vh ====
// Constants of the diagnostic trouble log: register map, fields, codes and reset values.
`ifndef DDL_CONSTS_VH
`define DDL_CONSTS_VH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses on the APB)
// ----------------------------------------------------------------------------
`define DDL_OFF_CTRL 12'h000
`define DDL_OFF_STAT 12'h004
`define DDL_OFF_MADDR 12'h008
`define DDL_OFF_SLVTAB 12'h040
`define DDL_OFF_SLVTAB_END 12'h05C
`define DDL_OFF_REC 12'h100
`define DDL_OFF_REC_END 12'h1FC
`define DDL_OFF_EXT_LEN 12'h200
`define DDL_OFF_EXT_OVR 12'h204
`define DDL_OFF_EXT_DATA 12'h208
`define DDL_OFF_EXT_END 12'h238

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DDL_CTRL_START 0
`define DDL_CTRL_CLR 2
`define DDL_CTRL_FIXED 3
`define DDL_CTRL_MRST 4
`define DDL_STAT_RUN 0
`define DDL_STAT_TROUBLE 1
`define DDL_STAT_FAULT 2
`define DDL_STAT_DUP 3
`define DDL_STAT_CNT_LSB 8
`define DDL_EXT_OVR_BIT 7

// ----------------------------------------------------------------------------
// Record codes and fill values
// ----------------------------------------------------------------------------
`define DDL_CODE_SLAVE_DIAG 16'h0200
`define DDL_LEN_SLAVE_DIAG 16'h0003
`define DDL_CODE_DUP_ADDR 16'h1121
`define DDL_CODE_HALT 16'h3000
`define DDL_LEN_ONE 16'h0001
`define DDL_DUP_DETAIL 16'h0003
`define DDL_FAIL_FILL 8'hFF
`define DDL_EXT_OVR_LIMIT 8'h1B

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DDL_RST_CTRL 16'h0000
`define DDL_RST_MADDR 8'h00
`define DDL_RST_SLVTAB 8'hFF

`endif

// ==== verilog/ddl_diag_log.v ====
// Diagnostic trouble log of a fieldbus master, with an APB register slave.
`timescale 1ns/100ps
`include "ddl_consts.vh"

// Notes on behaviour
// - Fixed mode, when full, overwrites only head.
// - Ring mode keeps newest at head, drops oldest.
// - Slave diagnostic logs code 0200, length three.
// - Details: addresses, diagnostic status, slave ident number.
// - Failed communication stores FF in both fields.
// - Expansion area holds only latest slave diagnostic.
// - Duplicate address logs 1121, length one, detail 03.
// - Duplicate check runs after reset, before exchange.
// - Start with duplicate error: log 3000, fault, halt.
// - Status bit 0: parameter assignment request.
// - Status bit 1: slave status error.
// - Status bits 2 and 6 always zero.
// - Bits 3,4,5: watchdog, freeze, sync modes.
// - Bit 7: cyclic communication removed by parameters.
// - Bit 8: master cannot reach slave.
// - Bit 9: slave not ready for exchange.
// - Bit 10: input/output length mismatch.
// - Bit 11: expansion diagnostic data received.
// - Bit 12: requested function not supported.
// - Bit 13: incorrect data from slave.
// - Bit 14: incorrect parameters sent to slave.
// - Bit 15: slave controlled by another master.
// - Control bit set selects fixed, clear ring.
// - Clear request erases all stored records.
// - Any slave diagnostic during exchange sets trouble flag in status.
module ddl_diag_log #(
	parameter NREC = 8,
	parameter NSLV = 8,
	parameter EXT_BYTES = 26
) (
	input wire sys_clk,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output wire pready,
	output reg [31:0] prdata,
	output reg pslverr,
	input wire diag_valid,
	input wire [7:0] diag_slave_addr,
	input wire [7:0] diag_ctrl_master,
	input wire [15:0] diag_slave_bits,
	input wire [15:0] slave_ident_number,
	input wire diag_comm_fail,
	input wire diag_cyclic_removed,
	input wire diag_bad_data,
	input wire diag_other_master,
	input wire ext_start,
	input wire ext_byte_valid,
	input wire [7:0] ext_byte,
	output wire exchanging,
	output reg fault_led
);

	// ------------------------------------------------------------------------
	// State machine codes
	// ------------------------------------------------------------------------
	localparam [1:0] ST_CHECK = 2'd0;
	localparam [1:0] ST_IDLE = 2'd1;
	localparam [1:0] ST_RUN = 2'd2;
	localparam [1:0] ST_HALT = 2'd3;

	// ------------------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------------------
	function in_range;
		input [11:0] a;
		input [11:0] lo;
		input [11:0] hi;
		begin
			in_range = (a >= lo) && (a <= hi);
		end
	endfunction

	function [15:0] merge16;
		input [15:0] old;
		input [31:0] wd;
		input [3:0] st;
		begin
			merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
		end
	endfunction

	// ------------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------------
	reg [15:0] ctrl;
	reg [7:0] master_addr;
	reg [7:0] slv_tab [0:NSLV-1];
	reg [79:0] rec [0:NREC-1];
	reg [7:0] ext_mem [0:EXT_BYTES-1];
	reg [7:0] ext_len;
	reg [3:0] rec_cnt;
	reg [1:0] state;
	reg [2:0] scan_idx;
	reg dup_err;
	reg trouble;

	wire wr = psel && penable && pwrite;
	wire setup = psel && !penable;
	wire clr_req = wr && (paddr == `DDL_OFF_CTRL) && pstrb[0] && pwdata[`DDL_CTRL_CLR];
	wire mrst_req = wr && (paddr == `DDL_OFF_CTRL) && pstrb[0] && pwdata[`DDL_CTRL_MRST];
	wire fixed_mode = ctrl[`DDL_CTRL_FIXED];
	wire start_req = ctrl[`DDL_CTRL_START];

	// Every register answers in the access cycle, so no wait state is ever inserted.
	assign pready = 1'b1;
	assign exchanging = (state == ST_RUN);

	// ------------------------------------------------------------------------
	// Diagnostic status word
	// ------------------------------------------------------------------------
	// Slave-reported bits pass straight through; master-side bits are made here.
	wire ext_seen = (ext_len != 8'h00);
	wire [15:0] diag_status = {
		diag_other_master,
		diag_slave_bits[14],
		diag_bad_data,
		diag_slave_bits[12],
		ext_seen,
		diag_slave_bits[10],
		diag_slave_bits[9],
		diag_comm_fail,
		diag_cyclic_removed,
		1'b0,
		diag_slave_bits[5:3],
		1'b0,
		diag_slave_bits[1],
		diag_slave_bits[0]
	};

	// ------------------------------------------------------------------------
	// Sequencer: duplicate check, exchange start, logging
	// ------------------------------------------------------------------------
	reg log_we;
	reg [79:0] new_rec;
	reg [1:0] next_state;

	always @* begin
		log_we = 1'b0;
		new_rec = 80'h0;
		next_state = state;
		case (state)
			ST_CHECK: begin
				if (slv_tab[scan_idx] == master_addr && !dup_err) begin
					log_we = 1'b1;
					new_rec = {`DDL_CODE_DUP_ADDR, `DDL_LEN_ONE, `DDL_DUP_DETAIL, 32'h0};
				end
				if (scan_idx == NSLV - 1) begin
					next_state = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (start_req && dup_err) begin
					log_we = 1'b1;
					new_rec = {`DDL_CODE_HALT, `DDL_LEN_ONE, 48'h0};
					next_state = ST_HALT;
				end else if (start_req) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (diag_valid) begin
					log_we = 1'b1;
					new_rec = {`DDL_CODE_SLAVE_DIAG, `DDL_LEN_SLAVE_DIAG,
						(diag_comm_fail ? `DDL_FAIL_FILL : diag_ctrl_master),
						diag_slave_addr, diag_status,
						(diag_comm_fail ? {8'h00, `DDL_FAIL_FILL} : slave_ident_number)};
				end
				if (!start_req) begin
					next_state = ST_IDLE;
				end
			end
			// Only a module reset or a bus reset leaves the halted state.
			ST_HALT: begin
				next_state = ST_HALT;
			end
			default: begin
				next_state = ST_CHECK;
			end
		endcase
	end

	// A module reset restarts the duplicate check so a corrected table is re-examined.
	always @(posedge sys_clk) begin
		if (rst || mrst_req) begin
			state <= ST_CHECK;
			scan_idx <= 3'd0;
			dup_err <= 1'b0;
			fault_led <= 1'b0;
		end else begin
			state <= next_state;
			if (state == ST_CHECK) begin
				scan_idx <= scan_idx + 3'd1;
				if (slv_tab[scan_idx] == master_addr) begin
					dup_err <= 1'b1;
				end
			end
			if (state == ST_IDLE && start_req && dup_err) begin
				fault_led <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Record store
	// ------------------------------------------------------------------------
	// An arriving record wins over a clear in the same cycle: the log is wiped and
	// the new record lands at the head.
	wire [3:0] cnt_eff = clr_req ? 4'd0 : rec_cnt;
	// Fixed mode fills the slots in order; once all are held only the head is rewritten.
	wire [2:0] fix_slot = (cnt_eff == NREC) ? 3'd0 : cnt_eff[2:0];

	genvar gi;
	generate
		for (gi = 0; gi < NREC; gi = gi + 1) begin : g_rec
			always @(posedge sys_clk) begin
				if (rst) begin
					rec[gi] <= 80'h0;
				end else if (log_we && !fixed_mode) begin
					if (gi == 0) begin
						rec[gi] <= new_rec;
					end else begin
						rec[gi] <= clr_req ? 80'h0 : rec[(gi == 0) ? 0 : gi - 1];
					end
				end else if (log_we && fix_slot == gi) begin
					rec[gi] <= new_rec;
				end else if (clr_req) begin
					rec[gi] <= 80'h0;
				end
			end
		end
	endgenerate

	always @(posedge sys_clk) begin
		if (rst) begin
			rec_cnt <= 4'd0;
		end else if (log_we) begin
			rec_cnt <= (cnt_eff == NREC) ? cnt_eff : cnt_eff + 4'd1;
		end else if (clr_req) begin
			rec_cnt <= 4'd0;
		end
	end

	// Trouble flag: an event in the clearing cycle keeps the flag set.
	always @(posedge sys_clk) begin
		if (rst) begin
			trouble <= 1'b0;
		end else if (state == ST_RUN && diag_valid) begin
			trouble <= 1'b1;
		end else if (clr_req) begin
			trouble <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// Expansion trouble area
	// ------------------------------------------------------------------------
	// Each new stream replaces the last, so only the newest slave record's data stays.
	// Bytes beyond the kept area only raise the length, which the overflow flag reports.
	always @(posedge sys_clk) begin
		if (rst) begin
			ext_len <= 8'h00;
		end else if (ext_start && exchanging) begin
			ext_len <= 8'h00;
		end else if (ext_byte_valid && exchanging && ext_len != 8'hFF) begin
			ext_len <= ext_len + 8'h01;
		end
	end

	generate
		for (gi = 0; gi < EXT_BYTES; gi = gi + 1) begin : g_ext
			always @(posedge sys_clk) begin
				if (rst) begin
					ext_mem[gi] <= 8'h00;
				end else if (ext_byte_valid && exchanging && !ext_start && ext_len == gi) begin
					ext_mem[gi] <= ext_byte;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------------------
	// Clear and module reset are commands; they never stay set in the control word.
	always @(posedge sys_clk) begin
		if (rst) begin
			ctrl <= `DDL_RST_CTRL;
			master_addr <= `DDL_RST_MADDR;
		end else if (wr && paddr == `DDL_OFF_CTRL) begin
			ctrl <= merge16(ctrl, pwdata & 32'h0000_0009, pstrb);
		end else if (wr && paddr == `DDL_OFF_MADDR && pstrb[0]) begin
			master_addr <= pwdata[7:0];
		end
	end

	generate
		for (gi = 0; gi < NSLV; gi = gi + 1) begin : g_tab
			always @(posedge sys_clk) begin
				if (rst) begin
					slv_tab[gi] <= `DDL_RST_SLVTAB;
				end else if (wr && pstrb[0] && paddr == `DDL_OFF_SLVTAB + gi * 4) begin
					slv_tab[gi] <= pwdata[7:0];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------------
	// Register reads, registered in the setup cycle
	// ------------------------------------------------------------------------
	reg [31:0] next_prdata;
	reg next_err;
	reg [79:0] rd_rec;
	reg [3:0] ext_k;

	always @* begin
		next_prdata = 32'h0000_0000;
		next_err = 1'b0;
		rd_rec = rec[paddr[7:5]];
		ext_k = paddr[5:2] - 4'd2;
		if (paddr[1:0] != 2'b00) begin
			next_err = 1'b1;
		end else if (paddr == `DDL_OFF_CTRL) begin
			next_prdata = {16'h0000, ctrl};
		end else if (paddr == `DDL_OFF_STAT) begin
			next_prdata = {20'h0_0000, rec_cnt, 4'h0, dup_err, fault_led, trouble, exchanging};
		end else if (paddr == `DDL_OFF_MADDR) begin
			next_prdata = {24'h00_0000, master_addr};
		end else if (in_range(paddr, `DDL_OFF_SLVTAB, `DDL_OFF_SLVTAB_END)) begin
			next_prdata = {24'h00_0000, slv_tab[paddr[4:2]]};
		end else if (in_range(paddr, `DDL_OFF_REC, `DDL_OFF_REC_END)) begin
			case (paddr[4:2])
				3'd0: next_prdata = {16'h0000, rd_rec[79:64]};
				3'd1: next_prdata = {16'h0000, rd_rec[63:48]};
				3'd2: next_prdata = {16'h0000, rd_rec[47:32]};
				3'd3: next_prdata = {16'h0000, rd_rec[31:16]};
				3'd4: next_prdata = {16'h0000, rd_rec[15:0]};
				default: next_prdata = 32'h0000_0000;
			endcase
		end else if (paddr == `DDL_OFF_EXT_LEN) begin
			next_prdata = {24'h00_0000, ext_len};
		end else if (paddr == `DDL_OFF_EXT_OVR) begin
			next_prdata = {24'h00_0000, (ext_len >= `DDL_EXT_OVR_LIMIT), 7'h00};
		end else if (in_range(paddr, `DDL_OFF_EXT_DATA, `DDL_OFF_EXT_END)) begin
			next_prdata = {16'h0000, ext_mem[{ext_k, 1'b1}], ext_mem[{ext_k, 1'b0}]};
		end else begin
			next_err = 1'b1;
		end
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata <= pwrite ? 32'h0000_0000 : next_prdata;
			pslverr <= next_err;
		end
	end

endmodule // ddl_diag_log

// ==== sim/ddl_apb_host.sv ====
// Host model: APB master that reaches the log registers.
`timescale 1ns/100ps
module ddl_apb_host (
	input wire sys_clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	input wire pready,
	input wire [31:0] prdata,
	input wire pslverr,
	output logic rd_done,
	output logic [31:0] rd_data,
	output logic rd_err,
	output logic hung
);
initial begin
	{psel, penable, pwrite, rd_done, rd_err, hung} = 6'h00;
	{paddr, pwdata, rd_data} = 0;
	pstrb = 4'hf;
end
// ------
// One transfer
// ------
// The wait is bounded so a stuck slave shows as hung, not as a frozen run.
task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
	integer n;
	@(posedge sys_clk);
	psel <= 1'b1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge sys_clk);
	penable <= 1'b1;
	n = 0;
	@(posedge sys_clk);
	while (pready !== 1'b1 && n < 64) begin
		n++;
		@(posedge sys_clk);
	end
	hung <= n >= 64;
	rd_data <= prdata;
	rd_err <= pslverr;
	rd_done <= !w;
	psel <= 1'b0;
	penable <= 1'b0;
	@(posedge sys_clk);
	rd_done <= 1'b0;
endtask
endmodule // ddl_apb_host

// ==== sim/ddl_diag_log_assertions.sv ====
// Checker of the trouble log port behaviour.
`timescale 1ns/100ps
`include "ddl_consts.vh"
module ddl_diag_log_assertions (
	input wire sys_clk,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	input wire [31:0] prdata,
	input wire diag_valid,
	input wire exchanging,
	input wire fault_led
);
default clocking cb @(posedge sys_clk); endclocking
default disable iff (rst);
wire wr_ctrl = psel && penable && pwrite && paddr == `DDL_OFF_CTRL && pstrb[0];
wire mrst_wr = wr_ctrl && pwdata[4];
wire rd_setup = psel && !penable && !pwrite;
wire rec_rd = rd_setup && paddr[11:8] == 4'h1;
// ------
// Sequences and properties
// ------
sequence s_clr;
	wr_ctrl && pwdata[2] && !pwdata[4] && exchanging && !diag_valid;
endsequence
sequence s_stat_rd;
	rd_setup && paddr == `DDL_OFF_STAT;
endsequence
a_clear_empties: assert property (s_clr ##1 (!diag_valid) [*2] ##1 s_stat_rd
	|=> prdata[11:8] == 4'h0) else $error("log not empty after clear");
a_count_max: assert property (s_stat_rd |=> prdata[11:8] <= 4'h8)
	else $error("record count above eight");
a_status_gaps: assert property (rec_rd && paddr[4:0] == 5'h0C
	|=> !prdata[2] && !prdata[6]) else $error("unused status bits set");
a_unused_words: assert property (rec_rd && paddr[4:0] >= 5'h14 |=> prdata == 32'h0000_0000)
	else $error("unused record word not zero");
a_stat_fault: assert property (s_stat_rd |=> prdata[2] == $past(fault_led))
	else $error("fault status differs from indicator");
a_halt_idle: assert property (fault_led |-> !exchanging)
	else $error("exchange while halted");
a_fault_held: assert property (fault_led && !mrst_wr && !$past(mrst_wr) |=> fault_led)
	else $error("fault cleared without reset");
a_scan_first: assert property ($fell(rst) |-> !exchanging [*8])
	else $error("exchange before address check");
a_mrst_scan: assert property (mrst_wr |=> ##1 !exchanging [*7])
	else $error("exchange before check after module reset");
endmodule // ddl_diag_log_assertions
bind ddl_diag_log ddl_diag_log_assertions u_chk (.sys_clk, .rst, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pstrb, .prdata, .diag_valid, .exchanging, .fault_led);

// ==== sim/ddl_diag_log_tb.sv ====
// Testbench of the trouble log, driven through the host model.
`timescale 1ns/100ps
`include "ddl_consts.vh"
module ddl_diag_log_tb;
logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, rd_done, rd_err, hung;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, rd_data;
logic [3:0] pstrb;
logic diag_valid, diag_comm_fail, diag_cyclic_removed, diag_bad_data, diag_other_master;
logic [7:0] diag_slave_addr, diag_ctrl_master, ext_byte, eb0, eb1;
logic [15:0] diag_slave_bits, slave_ident_number, d1 [256], d2 [256], d3 [256];
logic ext_start, ext_byte_valid, exchanging, fault_led;
logic [33:0] expq [$];
integer mismatches = 0, num_checks = 0, seed = 32'h6f2e, extlen = 0, i, k;
ddl_diag_log DUT (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
	.prdata, .pslverr, .diag_valid, .diag_slave_addr, .diag_ctrl_master, .diag_slave_bits,
	.slave_ident_number, .diag_comm_fail, .diag_cyclic_removed, .diag_bad_data,
	.diag_other_master, .ext_start, .ext_byte_valid, .ext_byte, .exchanging, .fault_led);
ddl_apb_host HOST (.sys_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
	.prdata, .pslverr, .rd_done, .rd_data, .rd_err, .hung);
initial begin
	sys_clk = 0;
	forever #5 sys_clk = ~sys_clk;
end
// ------
// Tasks
// ------
task end_sim;
	$display("checks %0d mismatches %0d", num_checks, mismatches);
	if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
	else $display("*** FAIL ***");
	$finish;
endtask
task chk(input string n, input logic [31:0] e, input logic [31:0] s);
	num_checks++;
	if (s !== e) begin
		mismatches++;
		$display("[ERR] %s exp %h got %h", n, e, s);
	end
endtask
// Expectation bit 33 skips the data, for errors and partly unknown words.
task rd(input logic [11:0] a, input logic [33:0] e);
	expq.push_back(e);
	HOST.xfer(1'b0, a, 32'h0000_0000);
endtask
task ev(input logic [7:0] sa, input logic cf);
	logic [15:0] b, id;
	logic [7:0] m;
	logic [2:0] f;
	b = 16'($random(seed));
	id = 16'($random(seed));
	m = 8'($random(seed));
	f = 3'($random(seed));
	@(posedge sys_clk);
	diag_valid <= 1'b1;
	diag_slave_addr <= sa;
	diag_ctrl_master <= m;
	diag_slave_bits <= b;
	slave_ident_number <= id;
	diag_comm_fail <= cf;
	{diag_cyclic_removed, diag_bad_data, diag_other_master} <= f;
	d1[sa] = {cf ? 8'hFF : m, sa};
	d2[sa] = {f[0], b[14], f[1], b[12], extlen != 0, b[10], b[9], cf, f[2], 1'b0,
		b[5:3], 1'b0, b[1:0]};
	d3[sa] = cf ? 16'h00FF : id;
	@(posedge sys_clk);
	diag_valid <= 1'b0;
endtask
task chkrec(input integer slot, input logic [7:0] sa);
	logic [11:0] a;
	a = `DDL_OFF_REC + 12'(slot * 32);
	rd(a, {18'h0, `DDL_CODE_SLAVE_DIAG});
	rd(a + 12'h004, {18'h0, `DDL_LEN_SLAVE_DIAG});
	rd(a + 12'h008, {18'h0, d1[sa]});
	rd(a + 12'h00C, {18'h0, d2[sa]});
	rd(a + 12'h010, {18'h0, d3[sa]});
endtask
task stream(input integer n);
	eb0 = 8'($random(seed));
	eb1 = 8'($random(seed));
	@(posedge sys_clk);
	ext_start <= 1'b1;
	for (k = 0; k < n; k++) begin
		@(posedge sys_clk);
		ext_start <= 1'b0;
		ext_byte_valid <= 1'b1;
		ext_byte <= k == 0 ? eb0 : k == 1 ? eb1 : 8'($random(seed));
	end
	@(posedge sys_clk);
	ext_byte_valid <= 1'b0;
	extlen = n;
endtask
always @(posedge sys_clk) begin
	if (hung === 1'b1) begin
		mismatches++;
		end_sim();
	end else if (rd_done === 1'b1) begin
		if (expq[0][33] === 1'b0) chk("prdata", expq[0][31:0], rd_data);
		chk("pslverr", {31'h0, expq[0][32]}, {31'h0, rd_err});
		void'(expq.pop_front());
	end
end
// ------
// Scenarios
// ------
initial begin
	rst = 1'b1;
	{diag_valid, diag_comm_fail, diag_cyclic_removed, diag_bad_data, diag_other_master} = 0;
	{diag_slave_addr, diag_ctrl_master, ext_byte, diag_slave_bits, slave_ident_number} = 0;
	{ext_start, ext_byte_valid} = 2'b00;
	repeat (3) @(posedge sys_clk);
	rst <= 1'b0;
	repeat (12) @(posedge sys_clk);
	rd(`DDL_OFF_CTRL, 34'h0);
	rd(`DDL_OFF_SLVTAB + 12'h004, 34'h0_0000_00FF);
	rd(12'h00C, 34'h3_0000_0000);
	HOST.xfer(1'b1, `DDL_OFF_CTRL, 32'h0000_0001);
	repeat (2) @(posedge sys_clk);
	for (i = 1; i < 10; i++) ev(8'(i), i == 5);
	rd(`DDL_OFF_STAT, 34'h0_0000_0803);
	for (i = 0; i < 8; i++) chkrec(i, 8'(9 - i));
	HOST.xfer(1'b1, `DDL_OFF_CTRL, 32'h0000_000D);
	rd(`DDL_OFF_STAT, 34'h0_0000_0001);
	stream(5);
	for (i = 17; i < 26; i++) begin
		if (i == 25) stream(3);
		ev(8'(i), 1'b0);
	end
	for (i = 0; i < 8; i++) chkrec(i, 8'(i == 0 ? 25 : 17 + i));
	rd(`DDL_OFF_EXT_LEN, 34'h0_0000_0003);
	rd(`DDL_OFF_EXT_DATA, {18'h0, eb1, eb0});
	rd(`DDL_OFF_EXT_OVR, 34'h0);
	HOST.xfer(1'b1, `DDL_OFF_MADDR, 32'h0000_0005);
	HOST.xfer(1'b1, `DDL_OFF_SLVTAB, 32'h0000_0005);
	HOST.xfer(1'b1, `DDL_OFF_CTRL, 32'h0000_0014);
	repeat (12) @(posedge sys_clk);
	chk("exchanging", 32'h0, {31'h0, exchanging});
	rd(`DDL_OFF_REC, {18'h0, `DDL_CODE_DUP_ADDR});
	rd(`DDL_OFF_REC + 12'h004, {18'h0, `DDL_LEN_ONE});
	rd(`DDL_OFF_REC + 12'h008, {18'h0, `DDL_DUP_DETAIL});
	rd(`DDL_OFF_REC + 12'h014, 34'h0);
	HOST.xfer(1'b1, `DDL_OFF_CTRL, 32'h0000_0001);
	for (k = 0; k < 20 && fault_led !== 1'b1; k++) @(posedge sys_clk);
	chk("fault_led", 32'h1, {31'h0, fault_led});
	chk("exchanging", 32'h0, {31'h0, exchanging});
	rd(`DDL_OFF_REC, {18'h0, `DDL_CODE_HALT});
	rd(`DDL_OFF_STAT, 34'h0_0000_020C);
	repeat (4) @(posedge sys_clk);
	if (expq.size() != 0) mismatches++;
	end_sim();
end
endmodule // ddl_diag_log_tb
